// File: hdl/crw_defines.svh
// Constants for the coupled RAM wrapper: widths, layout, reset values
`ifndef CRW_DEFINES_SVH
`define CRW_DEFINES_SVH
`define CRW_ADDR_W      13
`define CRW_DATA_W      64
`define CRW_CODE_W      8
`define CRW_BANK_W      36
`define CRW_BANK_DATA_W 32
`define CRW_BANK_CODE_W 4
`define CRW_DEPTH       8192
`define CRW_LAST_ADDR   13'h1FFF
`define CRW_ADDR_RST    13'h0000
`define CRW_INIT_DATA   64'h0000000000000000
`define CRW_INIT_CODE   8'h00
`endif

// File: hdl/crw_pkg.sv
// Types of the coupled RAM wrapper
package crw_pkg;
    typedef enum logic [1:0]
    {
        CRW_IDLE = 2'b00,
        CRW_INIT = 2'b01
    } crw_mode_t;
endpackage

// File: hdl/crw_bank.sv
// One 36-bit RAM bank of the coupled RAM wrapper
`timescale 1ns/1ns
`include "crw_defines.svh"
module crw_bank
(
    input  wire logic                     clk_in,
    input  wire logic                     cs_in,
    input  wire logic                     we_in,
    input  wire logic [`CRW_ADDR_W-1:0]   addr_in,
    input  wire logic [`CRW_BANK_W-1:0]   wdata_in,
    output logic      [`CRW_BANK_W-1:0]   rdata_out
);
    // Storage is flip-flops; no reset, contents come from auto-initialization
    logic [`CRW_BANK_W-1:0] mem_r [0:`CRW_DEPTH-1];

    always_ff @(posedge clk_in)
    begin
        if (cs_in && we_in)
        begin
            mem_r[addr_in] <= wdata_in;
        end
        if (cs_in && !we_in)
        begin
            rdata_out <= mem_r[addr_in];
        end
    end
endmodule // crw_bank

// File: hdl/crw_wrapper.sv
// Coupled RAM wrapper: data coupled memory port slave with two interleaved banks
//
// Notes on behaviour
// - Slave on the core port; each access carries 64 data and 8 code bits.
// - Reads return the stored code beside the data word.
// - Writes store the core's code output for the addressed word.
// - Core events raise separate single-bit and multi-bit error interrupts.
// - Addresses of single-bit and multi-bit errors are captured separately.
// - Address parity from the core is checked on every access outside initialization.
// - Bank selects are decoded twice; any mismatch is flagged.
// - Two 36-bit byte-interleaved banks, each with its own chip select; write enable and address are shared.
// - On request both banks are initialized with consistent data and code.
// - RAM port access information is offered to the trace module.
`timescale 1ns/1ns
`include "crw_defines.svh"
module crw_wrapper
(
    input  wire logic                    clk_in,
    input  wire logic                    rst_n_in,
    input  wire logic                    acc_en_in,
    input  wire logic                    acc_we_in,
    input  wire logic [`CRW_ADDR_W-1:0]  acc_addr_in,
    input  wire logic                    acc_addr_par_in,
    input  wire logic [`CRW_DATA_W-1:0]  acc_wdata_in,
    input  wire logic [`CRW_CODE_W-1:0]  acc_wcode_in,
    output logic      [`CRW_DATA_W-1:0]  acc_rdata_out,
    output logic      [`CRW_CODE_W-1:0]  acc_rcode_out,
    output logic                         acc_ready_out,
    input  wire logic                    evt_single_in,
    input  wire logic                    evt_multi_in,
    input  wire logic [`CRW_ADDR_W-1:0]  evt_addr_in,
    input  wire logic                    init_req_in,
    input  wire logic                    single_clr_in,
    input  wire logic                    multi_clr_in,
    input  wire logic                    par_clr_in,
    output logic                         irq_single_out,
    output logic                         irq_multi_out,
    output logic [`CRW_ADDR_W-1:0]       single_addr_out,
    output logic [`CRW_ADDR_W-1:0]       multi_addr_out,
    output logic                         par_err_out,
    output logic                         dec_err_out,
    output logic                         init_busy_out,
    output logic                         init_done_out,
    output logic                         trace_valid_out,
    output logic                         trace_we_out,
    output logic [`CRW_ADDR_W-1:0]       trace_addr_out
);
    // ==========================================================
    // State
    typedef struct packed
    {
        crw_pkg::crw_mode_t     mode;
        logic [`CRW_ADDR_W-1:0] init_addr;
        logic                   busy;
        logic                   init_done;
        logic                   irq_single;
        logic                   irq_multi;
        logic [`CRW_ADDR_W-1:0] single_addr;
        logic [`CRW_ADDR_W-1:0] multi_addr;
        logic                   par_err;
        logic                   dec_err;
        logic                   rd_pend;
        logic                   ready;
        logic                   trace_valid;
        logic                   trace_we;
        logic [`CRW_ADDR_W-1:0] trace_addr;
    } crw_state_t;

    crw_state_t st_r;
    crw_state_t st_nxt;

    // ==========================================================
    // Bank control
    logic                   par_ok;
    logic                   acc_ok;
    logic                   cs_even_a;
    logic                   cs_even_b;
    logic                   cs_odd_a;
    logic                   cs_odd_b;
    logic                   bank_we;
    logic [`CRW_ADDR_W-1:0] bank_addr;
    logic [`CRW_BANK_W-1:0] even_wdata;
    logic [`CRW_BANK_W-1:0] odd_wdata;
    logic [`CRW_BANK_W-1:0] even_rdata;
    logic [`CRW_BANK_W-1:0] odd_rdata;
    logic [`CRW_DATA_W-1:0] wdata_mux;
    logic [`CRW_CODE_W-1:0] wcode_mux;
    logic                   in_init;

    assign in_init   = (st_r.mode == crw_pkg::CRW_INIT);
    // Even parity over address plus parity bit; a bad address never reaches the banks
    assign par_ok    = ~(^{acc_addr_in, acc_addr_par_in});
    // A start of init wins over an access in the same cycle, so that access must not reach the banks
    assign acc_ok    = acc_en_in & par_ok & ~init_req_in;
    assign bank_we   = in_init | acc_we_in;
    assign bank_addr = in_init ? st_r.init_addr : acc_addr_in;
    // Two decoders: one positive, one by inverted logic; the even one reuses acc_ok, only the odd one decodes the raw inputs
    assign cs_even_a = in_init | acc_ok;
    assign cs_odd_a  = in_init | acc_ok;
    assign cs_even_b = ~(~in_init & ~acc_ok);
    assign cs_odd_b  = ~(~in_init & (~acc_en_in | ~par_ok | init_req_in));
    // Init writes an all-zero word with all-zero code, a valid codeword
    assign wdata_mux = in_init ? `CRW_INIT_DATA : acc_wdata_in;
    assign wcode_mux = in_init ? `CRW_INIT_CODE : acc_wcode_in;

    // Even bank: bytes 0,2,4,6 and code 3:0; odd bank: bytes 1,3,5,7 and code 7:4
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_lane
            assign even_wdata[gi*8 +: 8] = wdata_mux[gi*16 +: 8];
            assign odd_wdata[gi*8 +: 8]  = wdata_mux[gi*16+8 +: 8];
            assign acc_rdata_out[gi*16 +: 8]   = even_rdata[gi*8 +: 8];
            assign acc_rdata_out[gi*16+8 +: 8] = odd_rdata[gi*8 +: 8];
        end
    endgenerate
    assign even_wdata[`CRW_BANK_W-1:`CRW_BANK_DATA_W] = wcode_mux[3:0];
    assign odd_wdata[`CRW_BANK_W-1:`CRW_BANK_DATA_W]  = wcode_mux[7:4];
    assign acc_rcode_out = {odd_rdata[`CRW_BANK_W-1:`CRW_BANK_DATA_W],
                            even_rdata[`CRW_BANK_W-1:`CRW_BANK_DATA_W]};

    crw_bank u_even
    (
        .clk_in    (clk_in),
        .cs_in     (cs_even_a),
        .we_in     (bank_we),
        .addr_in   (bank_addr),
        .wdata_in  (even_wdata),
        .rdata_out (even_rdata)
    );

    crw_bank u_odd
    (
        .clk_in    (clk_in),
        .cs_in     (cs_odd_a),
        .we_in     (bank_we),
        .addr_in   (bank_addr),
        .wdata_in  (odd_wdata),
        .rdata_out (odd_rdata)
    );

    // ==========================================================
    // Next state
    always_comb
    begin
        st_nxt             = st_r;
        st_nxt.ready       = 1'b0;
        st_nxt.trace_valid = 1'b0;
        st_nxt.rd_pend     = 1'b0;
        case (st_r.mode)
            crw_pkg::CRW_IDLE:
            begin
                if (init_req_in)
                begin
                    st_nxt.mode      = crw_pkg::CRW_INIT;
                    st_nxt.busy      = 1'b1;
                    st_nxt.init_addr = `CRW_ADDR_RST;
                    st_nxt.init_done = 1'b0;
                end
                else if (acc_en_in && par_ok)
                begin
                    st_nxt.ready       = 1'b1;
                    st_nxt.trace_valid = 1'b1;
                    st_nxt.trace_we    = acc_we_in;
                    st_nxt.trace_addr  = acc_addr_in;
                end
            end
            crw_pkg::CRW_INIT:
            begin
                // Core accesses are held off while the banks are filled
                st_nxt.init_addr = st_r.init_addr + 13'h0001;
                if (st_r.init_addr == `CRW_LAST_ADDR)
                begin
                    st_nxt.mode      = crw_pkg::CRW_IDLE;
                    st_nxt.busy      = 1'b0;
                    st_nxt.init_done = 1'b1;
                end
            end
            default:
            begin
                st_nxt.mode = crw_pkg::CRW_IDLE;
                st_nxt.busy = 1'b0;
            end
        endcase
        // Set wins over clear for every sticky flag
        if (single_clr_in)
        begin
            st_nxt.irq_single = 1'b0;
        end
        if (evt_single_in)
        begin
            st_nxt.irq_single  = 1'b1;
            st_nxt.single_addr = evt_addr_in;
        end
        if (multi_clr_in)
        begin
            st_nxt.irq_multi = 1'b0;
        end
        if (evt_multi_in)
        begin
            st_nxt.irq_multi  = 1'b1;
            st_nxt.multi_addr = evt_addr_in;
        end
        if (par_clr_in)
        begin
            st_nxt.par_err = 1'b0;
            st_nxt.dec_err = 1'b0;
        end
        if (acc_en_in && !par_ok && !in_init)
        begin
            st_nxt.par_err = 1'b1;
        end
        if ((cs_even_a != cs_even_b) || (cs_odd_a != cs_odd_b))
        begin
            st_nxt.dec_err = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign acc_ready_out   = st_r.ready;
    assign irq_single_out  = st_r.irq_single;
    assign irq_multi_out   = st_r.irq_multi;
    assign single_addr_out = st_r.single_addr;
    assign multi_addr_out  = st_r.multi_addr;
    assign par_err_out     = st_r.par_err;
    assign dec_err_out     = st_r.dec_err;
    assign init_busy_out   = st_r.busy;
    assign init_done_out   = st_r.init_done;
    assign trace_valid_out = st_r.trace_valid;
    assign trace_we_out    = st_r.trace_we;
    assign trace_addr_out  = st_r.trace_addr;

    // ==========================================================
    // Checks
    sequence s_init_start;
        !in_init && init_req_in;
    endsequence

    sequence s_wr_take;
        !in_init && !init_req_in && acc_en_in && par_ok && acc_we_in;
    endsequence
    sequence s_rd_take;
        !in_init && !init_req_in && acc_en_in && par_ok && !acc_we_in;
    endsequence

    single_irq_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        evt_single_in |=> irq_single_out && single_addr_out == $past(evt_addr_in))
        else $error("single error not captured");
    multi_irq_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        evt_multi_in |=> irq_multi_out && multi_addr_out == $past(evt_addr_in))
        else $error("multi error not captured");
    irq_clear_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        single_clr_in && !evt_single_in |=> !irq_single_out)
        else $error("single flag not cleared");
    addr_parity_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        acc_en_in && !par_ok && !in_init |=> par_err_out && !acc_ready_out)
        else $error("bad address parity accepted");
    access_ready_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !in_init && !init_req_in && acc_en_in && par_ok |=> acc_ready_out && trace_valid_out)
        else $error("good access not answered");
    trace_addr_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        trace_valid_out |-> trace_addr_out == $past(acc_addr_in) && trace_we_out == $past(acc_we_in))
        else $error("trace information wrong");
    dec_match_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        cs_even_a == cs_even_b && cs_odd_a == cs_odd_b)
        else $error("redundant decoders disagree");
    init_seq_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_init_start |=> init_busy_out && st_r.init_addr == 13'h0000 ##1 st_r.init_addr == 13'h0001)
        else $error("init sequence wrong");
    read_code_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_wr_take ##1 !acc_en_in ##1 s_rd_take ##0 acc_addr_in == $past(acc_addr_in, 2)
        |=> acc_rcode_out == $past(acc_wcode_in, 3) && acc_rdata_out == $past(acc_wdata_in, 3))
        else $error("stored word not returned");
endmodule // crw_wrapper

// File: sim/crw_core_model.sv
// Core-side model of the data coupled memory port
`timescale 1ns/1ns
`include "crw_defines.svh"
module crw_core_model
(
    input  wire logic                   clk_in,
    input  wire logic                   acc_ready_in,
    input  wire logic [`CRW_DATA_W-1:0] acc_rdata_in,
    input  wire logic [`CRW_CODE_W-1:0] acc_rcode_in,
    output logic                        acc_en_out,
    output logic                        acc_we_out,
    output logic [`CRW_ADDR_W-1:0]      acc_addr_out,
    output logic                        acc_addr_par_out,
    output logic [`CRW_DATA_W-1:0]      acc_wdata_out,
    output logic [`CRW_CODE_W-1:0]      acc_wcode_out,
    output logic                        evt_single_out,
    output logic                        evt_multi_out,
    output logic [`CRW_ADDR_W-1:0]      evt_addr_out
);
    // ==========================================
    // Port drivers
    logic evt_on = 1'b0;
    initial
    begin
        {acc_en_out, acc_we_out, acc_addr_out, acc_addr_par_out} = '0;
        {acc_wdata_out, acc_wcode_out, evt_single_out, evt_multi_out, evt_addr_out} = '0;
    end
    // One request per call; lines not held are inverted, never left at the old value
    task automatic access(input logic we, input logic [12:0] a, input logic [63:0] wd, input logic [7:0] wc,
                          input logic bad, output logic rdy, output logic [63:0] rd, output logic [7:0] rc);
        @(posedge clk_in);
        acc_en_out       <= 1'b1;
        acc_we_out       <= we;
        acc_addr_out     <= a;
        acc_addr_par_out <= ^a ^ bad;
        acc_wdata_out    <= wd;
        acc_wcode_out    <= wc;
        @(posedge clk_in);
        acc_en_out       <= 1'b0;
        acc_we_out       <= ~we;
        acc_addr_out     <= ~a;
        acc_addr_par_out <= ~(^a ^ bad);
        acc_wdata_out    <= ~wd;
        acc_wcode_out    <= ~wc;
        @(negedge clk_in);
        rdy = acc_ready_in;
        rd  = acc_rdata_in;
        rc  = acc_rcode_in;
    endtask
    // Software must switch reporting on; it is off from reset
    task automatic enable_events();
        evt_on = 1'b1;
    endtask
    // Single-bit errors are corrected by the core, multi-bit only flagged
    task automatic report(input logic multi, input logic [12:0] a);
        @(posedge clk_in);
        evt_single_out <= evt_on & ~multi;
        evt_multi_out  <= evt_on & multi;
        evt_addr_out   <= a;
        @(posedge clk_in);
        evt_single_out <= 1'b0;
        evt_multi_out  <= 1'b0;
        evt_addr_out   <= ~a;
        @(negedge clk_in);
    endtask
endmodule // crw_core_model

// File: sim/tb_top.sv
// Self-checking bench of the coupled RAM wrapper
`timescale 1ns/1ns
`include "crw_defines.svh"
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
    $display("unexpected %s exp=%0h got=%0h", what, exp, got); end end
module tb_top;
    // ==========================================
    // Signals and instances
    logic clk_in = 0, rst_n_in = 0, init_req_in = 0, single_clr_in = 0, multi_clr_in = 0, par_clr_in = 0;
    wire acc_en_in, acc_we_in, acc_addr_par_in, evt_single_in, evt_multi_in, acc_ready_out;
    wire irq_single_out, irq_multi_out, par_err_out, dec_err_out, init_busy_out, init_done_out;
    wire trace_valid_out, trace_we_out;
    wire [12:0] acc_addr_in, evt_addr_in, single_addr_out, multi_addr_out, trace_addr_out;
    wire [63:0] acc_wdata_in, acc_rdata_out;
    wire [7:0]  acc_wcode_in, acc_rcode_out;
    int errors = 0, cmp_count = 0;
    logic rdy;
    logic [63:0] rd;
    logic [7:0] rc;
    crw_wrapper u_crw_wrapper (.clk_in, .rst_n_in, .acc_en_in, .acc_we_in, .acc_addr_in, .acc_addr_par_in,
        .acc_wdata_in, .acc_wcode_in, .acc_rdata_out, .acc_rcode_out, .acc_ready_out, .evt_single_in,
        .evt_multi_in, .evt_addr_in, .init_req_in, .single_clr_in, .multi_clr_in, .par_clr_in, .irq_single_out,
        .irq_multi_out, .single_addr_out, .multi_addr_out, .par_err_out, .dec_err_out, .init_busy_out,
        .init_done_out, .trace_valid_out, .trace_we_out, .trace_addr_out);
    crw_core_model u_crw_core_model (.clk_in, .acc_ready_in(acc_ready_out), .acc_rdata_in(acc_rdata_out),
        .acc_rcode_in(acc_rcode_out), .acc_en_out(acc_en_in), .acc_we_out(acc_we_in),
        .acc_addr_out(acc_addr_in), .acc_addr_par_out(acc_addr_par_in), .acc_wdata_out(acc_wdata_in),
        .acc_wcode_out(acc_wcode_in), .evt_single_out(evt_single_in), .evt_multi_out(evt_multi_in),
        .evt_addr_out(evt_addr_in));
    always #5 clk_in = ~clk_in;
    // ==========================================
    // Helpers
    task automatic conclude();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Reads back a word and checks data, code, handshake and trace
    task automatic read_chk(input logic [12:0] a, input logic [63:0] d, input logic [7:0] c);
        u_crw_core_model.access(1'b0, a, 64'h0, 8'h00, 1'b0, rdy, rd, rc);
        `CHK("ready", 1'b1, rdy)
        `CHK("rdata", d, rd)
        `CHK("rcode", c, rc)
        `CHK("trace", {1'b1, 1'b0, a}, {trace_valid_out, trace_we_out, trace_addr_out})
    endtask
    // One-cycle pulse on the strobes picked by sel: init, single clear, multi clear, parity clear
    task automatic pulse(input logic [3:0] sel);
        @(posedge clk_in);
        {init_req_in, single_clr_in, multi_clr_in, par_clr_in} <= sel;
        @(posedge clk_in);
        {init_req_in, single_clr_in, multi_clr_in, par_clr_in} <= 4'h0;
        @(negedge clk_in);
    endtask
    // ==========================================
    // Scenarios
    task automatic scn_init();
        int n;
        pulse(4'h8);
        `CHK("busy", 1'b1, init_busy_out)
        u_crw_core_model.access(1'b0, 13'h0005, 64'h0, 8'h00, 1'b0, rdy, rd, rc);
        `CHK("ready in init", 1'b0, rdy)
        for (n = 0; n < 9000 && init_busy_out !== 1'b0; n++)
            @(negedge clk_in);
        if (n == 9000)
        begin
            errors++;
            conclude();
        end
        `CHK("done", 1'b1, init_done_out)
        read_chk(13'h0000, `CRW_INIT_DATA, `CRW_INIT_CODE);
        read_chk(`CRW_LAST_ADDR, `CRW_INIT_DATA, `CRW_INIT_CODE);
    endtask
    task automatic scn_rw();
        u_crw_core_model.access(1'b1, 13'h0001, 64'h0123456789ABCDEF, 8'hA5, 1'b0, rdy, rd, rc);
        `CHK("wr ready", 1'b1, rdy)
        `CHK("wr trace", {1'b1, 13'h0001}, {trace_we_out, trace_addr_out})
        `CHK("even bank", 36'h52367ABEF, u_crw_wrapper.u_even.mem_r[1])
        `CHK("odd bank", 36'hA014589CD, u_crw_wrapper.u_odd.mem_r[1])
        u_crw_core_model.access(1'b1, `CRW_LAST_ADDR, 64'hFEDCBA9876543210, 8'h3C, 1'b0, rdy, rd, rc);
        // Reading the last written word first puts a write and a read of one word two cycles apart
        read_chk(`CRW_LAST_ADDR, 64'hFEDCBA9876543210, 8'h3C);
        read_chk(13'h0001, 64'h0123456789ABCDEF, 8'hA5);
    endtask
    task automatic scn_parity();
        u_crw_core_model.access(1'b1, 13'h0001, 64'h5555AAAA5555AAAA, 8'h0F, 1'b1, rdy, rd, rc);
        `CHK("bad par ready", 1'b0, rdy)
        `CHK("par_err", 1'b1, par_err_out)
        read_chk(13'h0001, 64'h0123456789ABCDEF, 8'hA5);
        pulse(4'h1);
        `CHK("par_err clr", 1'b0, par_err_out)
    endtask
    task automatic scn_events();
        u_crw_core_model.report(1'b0, 13'h0ABC);
        `CHK("irq off", 1'b0, irq_single_out)
        u_crw_core_model.enable_events();
        u_crw_core_model.report(1'b0, 13'h0ABC);
        `CHK("single", {1'b1, 1'b0, 13'h0ABC}, {irq_single_out, irq_multi_out, single_addr_out})
        u_crw_core_model.report(1'b1, 13'h1234);
        `CHK("multi", {1'b1, 13'h1234, 13'h0ABC}, {irq_multi_out, multi_addr_out, single_addr_out})
        pulse(4'h4);
        `CHK("single clr", 2'b01, {irq_single_out, irq_multi_out})
        fork
            u_crw_core_model.report(1'b0, 13'h0155);
            pulse(4'h4);
        join
        `CHK("set beats clr", {1'b1, 13'h0155}, {irq_single_out, single_addr_out})
        pulse(4'h2);
        `CHK("multi clr", 1'b0, irq_multi_out)
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(negedge clk_in);
        `CHK("reset flags", 6'h00, {irq_single_out, irq_multi_out, par_err_out, dec_err_out, init_busy_out,
             init_done_out})
        scn_init();
        scn_rw();
        scn_parity();
        scn_events();
        `CHK("dec_err", 1'b0, dec_err_out)
        conclude();
    end
endmodule // tb_top
